// file: core/fdw_pkg.sv
// Purpose: Shared constants and types for the four-channel output word link
// Assumes: 20 MHz sys_clk, one 16-bit word per transfer
// Notes: Word layout is sample[11:0], select[13:12], enable[14], sign[15]
package fdw_pkg;

  // Output word field layout
  localparam int SAMPLE_LSB = 0;
  localparam int SAMPLE_W = 12;
  localparam int SEL_LSB = 12;
  localparam int OE_BIT = 14;
  localparam int SIGN_BIT = 15;
  localparam logic [15:0] SAMPLE_MASK = 16'h0FFF;

  // Channel constants, each already carrying the enable bit
  localparam logic [3:0][15:0] CH_CONST = {16'h7000, 16'h6000, 16'h5000, 16'h4000};

  // Both byte lanes must be present for a full-width word
  localparam logic [1:0] LANES_FULL = 2'h3;

  // Code spans
  localparam int CODE_MAX = 4095;
  localparam int MAG_MAX = 2047;

  // Range spans in millivolts
  localparam int SPAN5_MV = 5000;
  localparam int SPAN10_MV = 10000;

  // Host scan period
  localparam int CLK_MHZ = 20;
  localparam int SCAN_TIME_US = 10;
  localparam int SCAN_CYC = SCAN_TIME_US * CLK_MHZ;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] IDX_RST = 4'h0;

  typedef enum logic [1:0] {
    FDW_RNG_U5 = 2'b00,
    FDW_RNG_U10 = 2'b01,
    FDW_RNG_B5 = 2'b10,
    FDW_RNG_B10 = 2'b11
  } fdw_range_t;

  typedef enum logic [1:0] {
    FDW_SEQ_FLAGS = 2'b00,
    FDW_SEQ_PTR = 2'b01,
    FDW_SEQ_ALL = 2'b10
  } fdw_seq_t;

  typedef enum logic [0:0] {
    FDW_H_IDLE = 1'b0,
    FDW_H_BURST = 1'b1
  } fdw_hstate_t;

endpackage

// file: core/fdw_if.sv
// Purpose: Word link between the controller scan logic and the output module
// Assumes: Both ends on sys_clk; host drives every signal from flip-flops
// Notes: lane_en marks which byte lanes carry valid data in a write
`timescale 1ns/10ps
`default_nettype none
interface fdw_if;
  logic [15:0] word;
  logic [1:0] lane_en;
  logic wr_stb;

  modport host (
    output word,
    output lane_en,
    output wr_stb
  );

  modport device (
    input word,
    input lane_en,
    input wr_stb
  );
endinterface
`default_nettype wire

// file: core/fdw_host.sv
// Purpose: Controller scan logic forming and sending output words
// Assumes: User inputs on sys_clk, sample values held steady by the user
// Notes: One word per scan in flag or pointer mode, four back to back in burst mode
`timescale 1ns/10ps
`default_nettype none
module fdw_host
  import fdw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  fdw_if.host lnk,
  // User side
  input wire logic [1:0] seq_mode,
  input wire logic permissive,
  input wire logic bcd_mode,
  input wire logic [3:0][15:0] sample_value,
  input wire logic [3:0] sample_neg,
  // Status
  output logic [1:0] cur_channel,
  output logic sequence_restart_flag,
  output logic [3:0] index_flags,
  output logic [1:0] channel_pointer_word,
  output logic scan_busy
);

  typedef struct packed {
    logic [7:0] scan_cnt;
    logic [3:0] idx;
    logic restart;
    logic [1:0] ptr;
    fdw_hstate_t st;
    logic [1:0] burst_ch;
    logic [1:0] ch;
    logic [15:0] word;
    logic [1:0] lanes;
    logic stb;
  } fdw_host_st_t;

  fdw_host_st_t cur_ff, nxt_ff;

  // Packed decimal to binary; only needed when host math is done in BCD
  function automatic logic [15:0] fdw_bcd2bin(input logic [15:0] b);
    logic [15:0] r;
    r = 16'((b[15:12] * 10'h3E8) + (b[11:8] * 7'h64) + (b[7:4] * 4'hA) + b[3:0]);
    return r;
  endfunction

  function automatic logic [15:0] fdw_form(input logic [1:0] ch, input logic [15:0] v,
                                           input logic neg, input logic bcd);
    logic [15:0] decimal_to_binary_conversion;
    logic [15:0] w;
    decimal_to_binary_conversion = bcd ? fdw_bcd2bin(v) : v;
    w = (decimal_to_binary_conversion & SAMPLE_MASK) | CH_CONST[ch];
    w[SIGN_BIT] = neg;
    return w;
  endfunction

  logic scan_tick;
  logic idx_onehot;

  assign scan_tick = (cur_ff.scan_cnt == 8'(SCAN_CYC - 1));
  assign idx_onehot = (cur_ff.idx == 4'h1) || (cur_ff.idx == 4'h2) || (cur_ff.idx == 4'h4) || (cur_ff.idx == 4'h8);

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.stb = 1'b0;
    nxt_ff.restart = 1'b0;
    nxt_ff.scan_cnt = scan_tick ? 8'h00 : 8'(cur_ff.scan_cnt + 8'h01);
    unique case (cur_ff.st)
      FDW_H_IDLE: begin
        if (scan_tick) begin
          unique case (seq_mode)
            FDW_SEQ_FLAGS: begin
              // Restart after ch4, on the first scan, or when no flag is sane
              if (!idx_onehot || cur_ff.idx == 4'h8) begin
                nxt_ff.idx = 4'h1;
                nxt_ff.restart = 1'b1;
                nxt_ff.ch = 2'h0;
              end else begin
                nxt_ff.idx = {cur_ff.idx[2:0], 1'b0};
                nxt_ff.ch = cur_ff.idx[0] ? 2'h1 : (cur_ff.idx[1] ? 2'h2 : 2'h3);
              end
              nxt_ff.word = fdw_form(nxt_ff.ch, sample_value[nxt_ff.ch], sample_neg[nxt_ff.ch], bcd_mode);
              nxt_ff.lanes = LANES_FULL;
              nxt_ff.stb = 1'b1;
            end
            FDW_SEQ_PTR: begin
              nxt_ff.ch = cur_ff.ptr;
              nxt_ff.ptr = 2'(cur_ff.ptr + 2'h1);
              nxt_ff.word = fdw_form(cur_ff.ptr, sample_value[cur_ff.ptr], sample_neg[cur_ff.ptr], bcd_mode);
              nxt_ff.lanes = LANES_FULL;
              nxt_ff.stb = 1'b1;
            end
            FDW_SEQ_ALL: begin
              // Burst lengthens the scan, so it only runs when permitted
              if (permissive) begin
                nxt_ff.st = FDW_H_BURST;
                nxt_ff.burst_ch = 2'h0;
              end
            end
            default: begin
              nxt_ff.st = FDW_H_IDLE;
            end
          endcase
        end
      end
      FDW_H_BURST: begin
        nxt_ff.ch = cur_ff.burst_ch;
        nxt_ff.word = fdw_form(cur_ff.burst_ch, sample_value[cur_ff.burst_ch],
                               sample_neg[cur_ff.burst_ch], bcd_mode);
        nxt_ff.lanes = LANES_FULL;
        nxt_ff.stb = 1'b1;
        nxt_ff.burst_ch = 2'(cur_ff.burst_ch + 2'h1);
        if (cur_ff.burst_ch == 2'h3) begin
          nxt_ff.st = FDW_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '{scan_cnt: 8'h00, idx: IDX_RST, restart: 1'b0, ptr: 2'h0, st: FDW_H_IDLE,
                  burst_ch: 2'h0, ch: 2'h0, word: WORD_RST, lanes: 2'h0, stb: 1'b0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign lnk.word = cur_ff.word;
  assign lnk.lane_en = cur_ff.lanes;
  assign lnk.wr_stb = cur_ff.stb;
  assign cur_channel = cur_ff.ch;
  assign sequence_restart_flag = cur_ff.restart;
  assign index_flags = cur_ff.idx;
  assign channel_pointer_word = cur_ff.ptr;
  assign scan_busy = (cur_ff.st == FDW_H_BURST);

endmodule
`default_nettype wire

// file: core/fdw_device.sv
// Purpose: Output module word decoder steering samples to four channels
// Assumes: Link on sys_clk; range and format straps come from outside and are synchronised
// Notes: Levels are signed millivolts; they follow a stored sample one cycle later
`timescale 1ns/10ps
`default_nettype none
module fdw_device
  import fdw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  fdw_if.device lnk,
  // Straps per channel: range select and signed format
  input wire logic [3:0][1:0] range_sel,
  input wire logic [3:0] fmt_signed,
  // Channel outputs
  output logic [3:0][11:0] ch_code,
  output logic [3:0] ch_sign,
  output logic [3:0][15:0] ch_level_mv,
  output logic [3:0][15:0] ch_drive_mv,
  output logic outputs_enabled,
  // Status
  output logic [1:0] last_channel,
  output logic update_pulse,
  output logic ignored_pulse,
  output logic [15:0] write_count,
  output logic [15:0] ignored_count
);

  typedef struct packed {
    logic [3:0][11:0] sample;
    logic [3:0] sign;
    logic oe;
    logic [3:0][15:0] level;
    logic [3:0][15:0] drive;
    logic [1:0] last_ch;
    logic upd;
    logic ign;
    logic [15:0] wr_cnt;
    logic [15:0] ign_cnt;
  } fdw_dev_st_t;

  fdw_dev_st_t cur_ff, nxt_ff;

  // Linear code to millivolt map; cfg is {signed format, range}
  function automatic logic [15:0] fdw_level(input logic [11:0] code, input logic neg,
                                            input logic [2:0] cfg);
    int c;
    int m;
    int s;
    int f;
    int r;
    logic bip;
    c = int'(code);
    bip = cfg[1];
    f = cfg[0] ? SPAN10_MV : SPAN5_MV;
    if (!cfg[2]) begin
      // Unsigned format spans the whole range
      if (bip) begin
        r = ((c * 2 * f) / CODE_MAX) - f;
      end else begin
        r = (c * f) / CODE_MAX;
      end
    end else begin
      // Magnitude above full scale is clipped rather than wrapped
      m = (c > MAG_MAX) ? MAG_MAX : c;
      s = neg ? -m : m;
      if (bip) begin
        r = (s * f) / MAG_MAX;
      end else begin
        r = ((s + MAG_MAX) * f) / CODE_MAX;
      end
    end
    return r[15:0];
  endfunction

  logic wr_full;
  logic wr_part;
  logic [1:0] sel;
  logic [11:0] smp;
  logic [3:0][2:0] cfg;

  // One filter per channel strap group; cfg is {signed format, range}
  for (genvar g = 0; g < 4; g++) begin : g_strap
    fdw_sync3 #(
      .W(3)
    ) i_fdw_sync3 (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .raw({fmt_signed[g], range_sel[g]}),
      .clean(cfg[g])
    );
  end

  assign wr_full = lnk.wr_stb && (lnk.lane_en == LANES_FULL);
  assign wr_part = lnk.wr_stb && (lnk.lane_en != LANES_FULL);
  assign sel = lnk.word[SEL_LSB +: 2];
  assign smp = lnk.word[SAMPLE_LSB +: SAMPLE_W];

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.upd = 1'b0;
    nxt_ff.ign = 1'b0;

    if (wr_full) begin
      // Only the selected channel takes the sample
      nxt_ff.sample[sel] = smp;
      nxt_ff.sign[sel] = lnk.word[SIGN_BIT];
      // Enable is global, not tied to the selected channel
      nxt_ff.oe = lnk.word[OE_BIT];
      nxt_ff.last_ch = sel;
      nxt_ff.upd = 1'b1;
      nxt_ff.wr_cnt = 16'(cur_ff.wr_cnt + 16'h0001);
    end else if (wr_part) begin
      // A partial word would mix stale lanes, so outputs stay as they are
      nxt_ff.ign = 1'b1;
      nxt_ff.ign_cnt = 16'(cur_ff.ign_cnt + 16'h0001);
    end

    for (int i = 0; i < 4; i++) begin
      nxt_ff.level[i] = fdw_level(cur_ff.sample[i], cur_ff.sign[i], cfg[i]);
      nxt_ff.drive[i] = cur_ff.oe ? nxt_ff.level[i] : 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign ch_code = cur_ff.sample;
  assign ch_sign = cur_ff.sign;
  assign ch_level_mv = cur_ff.level;
  assign ch_drive_mv = cur_ff.drive;
  assign outputs_enabled = cur_ff.oe;
  assign last_channel = cur_ff.last_ch;
  assign update_pulse = cur_ff.upd;
  assign ignored_pulse = cur_ff.ign;
  assign write_count = cur_ff.wr_cnt;
  assign ignored_count = cur_ff.ign_cnt;

endmodule

// Three-stage strap filter; a change passes once stages two and three agree
// Costs four cycles of latency, harmless for straps that move only at setup
module fdw_sync3 #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Strap in, filtered value out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } fdw_sync_st_t;

  fdw_sync_st_t cur_ff, nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    // Stage one feeds only stage two, so a metastable stage never reaches logic
    nxt_ff.s1 = raw;
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.s3 = cur_ff.s2;
    // Disagreeing stages mean a change in flight; keep the old value
    if (cur_ff.s2 == cur_ff.s3) begin
      nxt_ff.val = cur_ff.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign clean = cur_ff.val;

endmodule
`default_nettype wire

// file: sim/fdw_chk.sv
// Purpose: Link checks between host scan logic and output module
// Assumes: One clock domain, async active-low reset
// Notes: Sees only the word link signals
`timescale 1ns/10ps
`default_nettype none
module fdw_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link
  input wire logic [15:0] word,
  input wire logic [1:0] lane_en,
  input wire logic wr_stb
);
  logic [1:0] last_sel_ff;
  logic [7:0] since_rst_ff;

  // Starts at channel 4 so the first write must pick channel 1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_sel_ff <= 2'h3;
      since_rst_ff <= 8'h00;
    end else begin
      if (wr_stb) last_sel_ff <= word[13:12];
      if (since_rst_ff != 8'hFF) since_rst_ff <= since_rst_ff + 8'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  full_word_a: assert property (wr_stb |-> lane_en == 2'h3)
    else $error("partial word sent");
  enable_set_a: assert property (wr_stb |-> word[14])
    else $error("write without enable bit");
  burst_step_a: assert property (wr_stb && $past(wr_stb) |-> word[13:12] == $past(word[13:12]) + 2'h1)
    else $error("burst channel not stepped");
  burst_len_a: assert property (wr_stb [*4] |=> !wr_stb)
    else $error("burst longer than four");
  scan_gap_a: assert property ($fell(wr_stb) |-> !wr_stb [*8])
    else $error("write too soon after scan");
  chan_order_a: assert property (wr_stb |-> word[13:12] == last_sel_ff + 2'h1 || word[13:12] == 2'h0)
    else $error("channel out of order");
  word_hold_a: assert property (!wr_stb |-> $stable(word) && $stable(lane_en))
    else $error("word moved without strobe");
  first_scan_a: assert property (wr_stb |-> since_rst_ff >= 8'hBE)
    else $error("write before first scan");

  cover property (wr_stb [*4]);
  cover property (wr_stb && word[13:12] == 2'h3);
  cover property (wr_stb && word[15]);
endmodule
`default_nettype wire

// file: sim/tb_four_channel_dac_word_decoder.sv
// Purpose: Host and output module joined end to end, plus a rule-breaking driver
// Assumes: 20 MHz clock, scan tick every 200 cycles
// Notes: Second device takes hand-made words, partial and disabled ones too
`timescale 1ns/10ps
`default_nettype none
module tb_four_channel_dac_word_decoder;
  import fdw_pkg::*;
  logic sys_clk;
  logic resetn;
  logic [1:0] seq_mode;
  logic permissive;
  logic bcd_mode;
  logic [3:0][15:0] sample_value;
  logic [3:0] sample_neg;
  logic [3:0][1:0] range_sel;
  logic [3:0] fmt_signed;
  logic [3:0][11:0] code1, code2, ecode;
  logic [3:0][15:0] lvl1, drv1, lvl2, drv2;
  logic [3:0] sign1, esign;
  logic [1:0] last1;
  logic [15:0] wcnt1;
  logic [3:0] idx1;
  logic [1:0] ptr1;
  logic [15:0] icnt2;
  logic oe1, upd1, oe2, ign2;
  int bad_count = 0;
  int checked = 0;
  int nwr = 0;
  logic [3:0][11:0] bcd_bin = {12'h000, 12'hFFF, 12'h3E7, 12'h4D2};

  fdw_if lnk();
  fdw_if lnk2();
  fdw_host i_fdw_host (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk), .seq_mode(seq_mode),
    .permissive(permissive), .bcd_mode(bcd_mode), .sample_value(sample_value), .sample_neg(sample_neg),
    .cur_channel(), .sequence_restart_flag(), .index_flags(idx1), .channel_pointer_word(ptr1), .scan_busy());
  fdw_device i_fdw_device (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk), .range_sel(range_sel),
    .fmt_signed(fmt_signed), .ch_code(code1), .ch_sign(sign1), .ch_level_mv(lvl1), .ch_drive_mv(drv1),
    .outputs_enabled(oe1), .last_channel(last1), .update_pulse(upd1), .ignored_pulse(),
    .write_count(wcnt1), .ignored_count());
  fdw_device i_fdw_device_2 (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk2), .range_sel(range_sel),
    .fmt_signed(fmt_signed), .ch_code(code2), .ch_sign(), .ch_level_mv(lvl2), .ch_drive_mv(drv2),
    .outputs_enabled(oe2), .last_channel(), .update_pulse(), .ignored_pulse(ign2),
    .write_count(), .ignored_count(icnt2));
  fdw_chk i_fdw_chk (.sys_clk(sys_clk), .resetn(resetn), .word(lnk.word), .lane_en(lnk.lane_en),
    .wr_stb(lnk.wr_stb));

  task automatic print_verdict();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] mv(input logic [1:0] r, input logic sg, input logic [11:0] c, input logic ng);
    int f;
    int s;
    int v;
    f = r[0] ? 10000 : 5000;
    s = (sg && c > 12'h7FF) ? 2047 : int'(c);
    if (sg && ng) s = -s;
    if (!sg) v = r[1] ? 2 * f * s / 4095 - f : f * s / 4095;
    else v = r[1] ? s * f / 2047 : (s + 2047) * f / 4095;
    return v[15:0];
  endfunction

  task automatic lvlc(input int ch);
    chk(lvl1[ch], mv(range_sel[ch], fmt_signed[ch], ecode[ch], esign[ch]));
    chk(drv1[ch], mv(range_sel[ch], fmt_signed[ch], ecode[ch], esign[ch]));
  endtask

  // Bounded wait for the next stored word, then check every channel's code and the written channel's sign, plus its level when lv is set
  task automatic upd(input int ch, input logic [11:0] code, input logic ng, input bit lv);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 500) begin
        bad_count++;
        print_verdict();
      end
    end while (upd1 !== 1'b1);
    nwr++;
    ecode[ch] = code;
    esign[ch] = ng;
    chk(last1, 16'(ch));
    chk(oe1, 1'b1);
    chk(sign1[ch], ng);
    for (int i = 0; i < 4; i++) chk(code1[i], ecode[i]);
    if (lv) begin
      @(negedge sys_clk);
      lvlc(ch);
    end
  endtask

  task automatic drv(input logic [15:0] w, input logic [1:0] ln);
    @(posedge sys_clk);
    lnk2.word <= w;
    lnk2.lane_en <= ln;
    lnk2.wr_stb <= 1'b1;
    @(posedge sys_clk);
    lnk2.wr_stb <= 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    resetn = 1'b0;
    seq_mode = 2'h0;
    permissive = 1'b0;
    bcd_mode = 1'b0;
    sample_value = {16'h0000, 16'h0FFF, 16'h0800, 16'hF123};
    sample_neg = 4'h0;
    range_sel = {2'h3, 2'h2, 2'h1, 2'h0};
    fmt_signed = 4'h0;
    lnk2.word = 16'h0000;
    lnk2.lane_en = 2'h0;
    lnk2.wr_stb = 1'b0;
    ecode = '0;
    esign = '0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) upd(i % 4, sample_value[i % 4][11:0], 1'b0, 1'b1);
    chk(idx1, 16'h0001);
    @(posedge sys_clk);
    seq_mode <= 2'h1;
    fmt_signed <= 4'hF;
    sample_neg <= 4'hA;
    sample_value <= {16'h0001, 16'h0400, 16'h07FF, 16'h0FFF};
    // Let the new values settle before the expectations read them
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) upd(i % 4, sample_value[i % 4][11:0], sample_neg[i % 4], 1'b1);
    chk(ptr1, 16'h0001);
    @(posedge sys_clk);
    bcd_mode <= 1'b1;
    fmt_signed <= 4'h0;
    sample_neg <= 4'h0;
    sample_value <= {16'h0000, 16'h4095, 16'h0999, 16'h1234};
    for (int i = 1; i < 5; i++) upd(i % 4, bcd_bin[i % 4], 1'b0, 1'b1);
    @(posedge sys_clk);
    seq_mode <= 2'h2;
    bcd_mode <= 1'b0;
    fmt_signed <= 4'h5;
    sample_neg <= 4'h3;
    sample_value <= {16'h0FFE, 16'h0001, 16'h0555, 16'h0AAA};
    repeat (450) @(posedge sys_clk);
    chk(wcnt1, 16'(nwr));
    permissive <= 1'b1;
    for (int i = 0; i < 4; i++) upd(i, sample_value[i][11:0], sample_neg[i], 1'b0);
    @(negedge sys_clk);
    for (int i = 0; i < 4; i++) lvlc(i);
    @(posedge sys_clk);
    seq_mode <= 2'h3;
    drv(16'h2ABC, 2'h3);
    chk(code2[2], 16'h0ABC);
    chk(oe2, 1'b0);
    @(negedge sys_clk);
    chk(drv2[2], 16'h0000);
    drv(16'hF555, 2'h1);
    chk(ign2, 1'b1);
    drv(16'h7555, 2'h2);
    chk(code2[3], 16'h0000);
    drv(16'h4001, 2'h3);
    @(negedge sys_clk);
    chk(drv2[2], mv(range_sel[2], fmt_signed[2], 12'hABC, 1'b0));
    chk(icnt2, 16'h0002);
    print_verdict();
  end
endmodule
`default_nettype wire
